/* rtl/mfid_pkg.sv */
// shared constants, register map and carrier types of the input dispatch block
package mfid_pkg;
	localparam int MFID_CODE_W = 8;
	localparam int MFID_MAX_TERM = 4;
	localparam int MFID_EV_W = 5;

	// function codes of a multifunction_input_terminal
	localparam logic [7:0] MFID_CODE_REV_JOG = 8'h19;
	localparam logic [7:0] MFID_CODE_EMERG = 8'h1c;
	localparam logic [7:0] MFID_CODE_CURVE1 = 8'h1d;
	localparam logic [7:0] MFID_CODE_CURVE2 = 8'h1e;
	localparam logic [7:0] MFID_CODE_NV_BLOCK = 8'h26;
	localparam logic [7:0] MFID_CODE_COAST = 8'h28;
	localparam logic [7:0] MFID_CODE_HAND = 8'h29;
	localparam logic [7:0] MFID_CODE_AUTO = 8'h2a;

	// apb register byte addresses
	localparam int MFID_AW = 8;
	localparam logic [7:0] MFID_OFS_FUNC = 8'h00;
	localparam logic [7:0] MFID_OFS_CTRL = 8'h04;
	localparam logic [7:0] MFID_OFS_NVREQ = 8'h08;
	localparam logic [7:0] MFID_OFS_STATUS = 8'h0c;
	localparam logic [7:0] MFID_OFS_IRQ_STAT = 8'h10;
	localparam logic [7:0] MFID_OFS_IRQ_MASK = 8'h14;

	// reset values
	localparam logic [31:0] MFID_RST_FUNC = 32'h00000000;
	localparam logic [3:0] MFID_RST_CTRL = 4'h0;
	localparam logic [4:0] MFID_RST_MASK = 5'h00;

	// control and nv request register fields
	localparam int MFID_CTRL_RUN = 0;
	localparam int MFID_CTRL_SRC_EXT = 1;
	localparam int MFID_CTRL_TORQUE = 2;
	localparam int MFID_CTRL_VF = 3;
	localparam int MFID_NVREQ_GO = 0;

	// status register fields
	localparam int MFID_ST_RUN = 0;
	localparam int MFID_ST_JOG = 1;
	localparam int MFID_ST_FAULT = 2;
	localparam int MFID_ST_COAST = 3;
	localparam int MFID_ST_CURVE1 = 4;
	localparam int MFID_ST_CURVE2 = 5;
	localparam int MFID_ST_TORQUE = 6;
	localparam int MFID_ST_NV_BLOCK = 7;
	localparam int MFID_ST_HAND = 8;
	localparam int MFID_ST_AUTO = 9;
	localparam int MFID_ST_STOPPING = 10;
	localparam int MFID_ST_TERM = 16;

	// event / interrupt bits
	localparam int MFID_EV_FAULT = 0;
	localparam int MFID_EV_COAST = 1;
	localparam int MFID_EV_HAND_STOP = 2;
	localparam int MFID_EV_MODE = 3;
	localparam int MFID_EV_NV_REFUSED = 4;

	typedef enum logic [1:0] {MFID_MODE_OFF, MFID_MODE_HAND, MFID_MODE_AUTO, MFID_MODE_STOPPING}
		mfid_mode_t;

	typedef struct packed {
		logic run;
		logic jog_rev;
		logic gate_on;
		logic torque_mode;
		logic curve_first;
		logic curve_second;
		logic fault_ind;
		logic hand;
		logic auto_op;
	} mfid_drive_t;
endpackage

/* rtl/mfid_in_sync.sv */
// two-stage synchroniser with level and edge outputs for terminal pins
`timescale 1ns/10ps
module mfid_in_sync
	import mfid_pkg::*;
#(
	parameter int W = 5
)
(
	input wire logic mclk,
	input wire logic resetn,
	input wire logic [W-1:0] pin,
	output logic [W-1:0] level,
	output logic [W-1:0] rise,
	output logic [W-1:0] fall
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] cur;
		logic [W-1:0] prev;
	} mfid_sync_t;

	mfid_sync_t s;
	mfid_sync_t next_s;

	initial
	begin
		if (W < 1)
			$error("mfid_in_sync: W must be at least 1");
	end

	always_comb
	begin
		next_s.meta = pin;
		next_s.cur = s.meta;
		next_s.prev = s.cur;
	end

	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			s <= '0;
		else
			s <= next_s;
	end

	// meta feeds only cur; edges compare the two settled stages
	assign level = s.cur;
	assign rise = s.cur & ~s.prev;
	assign fall = ~s.cur & s.prev;
endmodule

/* rtl/mfid_dispatch.sv */
// multifunction input dispatch: terminal function decode, drive control, apb registers
//
// How it works
// - code 25 terminal on runs reverse jog, only with external run source.
// - jog in torque control uses speed control, torque returns after jog.
// - code 28 on stops output at once, motor coasts, emergency fault shown.
// - emergency fault holds stop until input removed and keypad reset given.
// - in v/f control, code 29 on selects the first curve.
// - in v/f control, code 30 on selects the second curve.
// - code 38 on blocks every nonvolatile parameter write.
// - code 40 on during operation removes output, motor coasts to stop.
// - hand terminal (code 41) turning off acts as a stop command.
// - hand/auto selection change stops drive first, then enters new mode.
//
// Our own choices: the APB register port and the address map.
`timescale 1ns/10ps
module mfid_dispatch
	import mfid_pkg::*;
#(
	parameter int NUM_TERM = 4
)
(
	input wire logic mclk,
	input wire logic resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [MFID_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [NUM_TERM-1:0] term_in,
	input wire logic keypad_reset,
	input wire logic motor_stopped,
	output mfid_drive_t drive_ctl,
	output logic nv_write,
	output logic irq
);
	localparam int FW = NUM_TERM * MFID_CODE_W;

	typedef struct packed {
		logic [FW-1:0] func;
		logic [3:0] ctrl;
		logic fault;
		mfid_mode_t mode;
		mfid_mode_t target;
		mfid_drive_t drv;
		logic nv_write;
		logic [MFID_EV_W-1:0] irq_stat;
		logic [MFID_EV_W-1:0] irq_mask;
		logic irq;
		logic ready;
		logic slverr;
		logic [31:0] rdata;
	} mfid_state_t;

	mfid_state_t s;
	mfid_state_t next_s;
	logic [NUM_TERM:0] in_level;
	logic [NUM_TERM:0] in_rise;
	logic [NUM_TERM:0] in_fall;

	initial
	begin
		if (NUM_TERM < 1 || NUM_TERM > MFID_MAX_TERM)
			$error("mfid_dispatch: NUM_TERM must be 1 to 4");
	end

	// pins come from switch contacts, outside the clock domain
	mfid_in_sync #(.W(NUM_TERM + 1)) u_sync
	(
		.mclk(mclk),
		.resetn(resetn),
		.pin({keypad_reset, term_in}),
		.level(in_level),
		.rise(in_rise),
		.fall(in_fall)
	);

	always_comb
	begin
		logic [7:0] code;
		logic act_jog;
		logic act_emerg;
		logic act_c1;
		logic act_c2;
		logic act_nv;
		logic act_coast;
		logic rise_coast;
		logic hand_on;
		logic hand_fall;
		logic auto_on;
		logic kp_rise;
		logic access;
		logic wr;
		logic running;
		logic jog;
		logic run_out;
		mfid_mode_t want;
		logic [MFID_EV_W-1:0] ev;
		logic [MFID_EV_W-1:0] w1c;
		logic [31:0] st;
		code = 8'h00;
		act_jog = 1'b0;
		act_emerg = 1'b0;
		act_c1 = 1'b0;
		act_c2 = 1'b0;
		act_nv = 1'b0;
		act_coast = 1'b0;
		rise_coast = 1'b0;
		hand_on = 1'b0;
		hand_fall = 1'b0;
		auto_on = 1'b0;
		kp_rise = in_rise[NUM_TERM];
		access = 1'b0;
		wr = 1'b0;
		running = 1'b0;
		jog = 1'b0;
		run_out = 1'b0;
		want = MFID_MODE_OFF;
		st = '0;
		ev = '0;
		w1c = '0;
		next_s = s;
		next_s.nv_write = 1'b0;

		// route each terminal by its own code; other codes fall through unused
		for (int i = 0; i < NUM_TERM; i++)
		begin
			code = s.func[i*MFID_CODE_W +: MFID_CODE_W];
			unique case (code)
				MFID_CODE_REV_JOG: act_jog = act_jog | in_level[i];
				MFID_CODE_EMERG: act_emerg = act_emerg | in_level[i];
				MFID_CODE_CURVE1: act_c1 = act_c1 | in_level[i];
				MFID_CODE_CURVE2: act_c2 = act_c2 | in_level[i];
				MFID_CODE_NV_BLOCK: act_nv = act_nv | in_level[i];
				MFID_CODE_COAST:
				begin
					act_coast = act_coast | in_level[i];
					rise_coast = rise_coast | in_rise[i];
				end
				MFID_CODE_HAND:
				begin
					hand_on = hand_on | in_level[i];
					hand_fall = hand_fall | in_fall[i];
				end
				MFID_CODE_AUTO: auto_on = auto_on | in_level[i];
				default: ;
			endcase
		end

		// apb: data prepared in setup, answered in the single access cycle
		access = psel & penable & s.ready;
		wr = access & pwrite;
		next_s.ready = psel & ~penable;
		next_s.slverr = 1'b0;
		if (wr)
		begin
			unique case (paddr)
				MFID_OFS_FUNC: next_s.func = pwdata[FW-1:0];
				MFID_OFS_CTRL: next_s.ctrl = pwdata[3:0];
				MFID_OFS_NVREQ:
				begin
					if (pwdata[MFID_NVREQ_GO])
					begin
						if (act_nv)
							ev[MFID_EV_NV_REFUSED] = 1'b1;
						else
							next_s.nv_write = 1'b1;
					end
				end
				MFID_OFS_IRQ_STAT: w1c = pwdata[MFID_EV_W-1:0];
				MFID_OFS_IRQ_MASK: next_s.irq_mask = pwdata[MFID_EV_W-1:0];
				default: ;
			endcase
		end

		// emergency fault: set wins over a keypad reset in the same cycle
		if (act_emerg)
		begin
			if (!s.fault)
				ev[MFID_EV_FAULT] = 1'b1;
			next_s.fault = 1'b1;
		end
		else if (kp_rise)
			next_s.fault = 1'b0;
		running = s.drv.run;

		// hand/auto selection; both or neither counts as off
		if (hand_on && !auto_on)
			want = MFID_MODE_HAND;
		else if (auto_on && !hand_on)
			want = MFID_MODE_AUTO;
		else
			want = MFID_MODE_OFF;
		unique case (s.mode)
			MFID_MODE_STOPPING:
			begin
				next_s.target = want;
				next_s.ctrl[MFID_CTRL_RUN] = 1'b0;
				if (motor_stopped && !running)
				begin
					next_s.mode = want;
					ev[MFID_EV_MODE] = 1'b1;
				end
			end
			default:
			begin
				if (want != s.mode)
				begin
					next_s.mode = MFID_MODE_STOPPING;
					next_s.target = want;
					next_s.ctrl[MFID_CTRL_RUN] = 1'b0;
				end
			end
		endcase

		// hand terminal dropping is a stop command
		if (hand_fall)
		begin
			next_s.ctrl[MFID_CTRL_RUN] = 1'b0;
			if (running)
				ev[MFID_EV_HAND_STOP] = 1'b1;
		end
		// coasting while running drops the run request so the motor stays stopped
		if (act_coast && running)
		begin
			next_s.ctrl[MFID_CTRL_RUN] = 1'b0;
			if (rise_coast)
				ev[MFID_EV_COAST] = 1'b1;
		end
		if (act_emerg)
			next_s.ctrl[MFID_CTRL_RUN] = 1'b0;

		// a software write to the run bit in this cycle still yields to the stops above
		jog = act_jog & s.ctrl[MFID_CTRL_SRC_EXT] & ~next_s.fault & ~act_coast
			& (next_s.mode != MFID_MODE_STOPPING);
		run_out = (next_s.ctrl[MFID_CTRL_RUN] | jog) & ~next_s.fault & ~act_coast
			& (next_s.mode != MFID_MODE_STOPPING);
		next_s.drv.run = run_out;
		next_s.drv.jog_rev = jog;
		next_s.drv.gate_on = run_out & ~next_s.fault & ~act_coast;
		next_s.drv.torque_mode = s.ctrl[MFID_CTRL_TORQUE] & ~jog;
		// first curve wins when both curve inputs are on
		next_s.drv.curve_first = s.ctrl[MFID_CTRL_VF] & act_c1;
		next_s.drv.curve_second = s.ctrl[MFID_CTRL_VF] & act_c2 & ~act_c1;
		next_s.drv.fault_ind = next_s.fault;
		next_s.drv.hand = (next_s.mode == MFID_MODE_HAND);
		next_s.drv.auto_op = (next_s.mode == MFID_MODE_AUTO);

		// sticky events: a new event beats a same-cycle clear
		next_s.irq_stat = (s.irq_stat & ~w1c) | ev;
		next_s.irq = |(next_s.irq_stat & next_s.irq_mask);

		st = '0;
		st[MFID_ST_RUN] = s.drv.run;
		st[MFID_ST_JOG] = s.drv.jog_rev;
		st[MFID_ST_FAULT] = s.fault;
		st[MFID_ST_COAST] = act_coast;
		st[MFID_ST_CURVE1] = s.drv.curve_first;
		st[MFID_ST_CURVE2] = s.drv.curve_second;
		st[MFID_ST_TORQUE] = s.drv.torque_mode;
		st[MFID_ST_NV_BLOCK] = act_nv;
		st[MFID_ST_HAND] = s.drv.hand;
		st[MFID_ST_AUTO] = s.drv.auto_op;
		st[MFID_ST_STOPPING] = (s.mode == MFID_MODE_STOPPING);
		st[MFID_ST_TERM +: NUM_TERM] = in_level[NUM_TERM-1:0];

		next_s.rdata = '0;
		if (psel && !penable)
		begin
			unique case (paddr)
				MFID_OFS_FUNC: next_s.rdata[FW-1:0] = s.func;
				MFID_OFS_CTRL: next_s.rdata[3:0] = s.ctrl;
				MFID_OFS_NVREQ: next_s.rdata = '0;
				MFID_OFS_STATUS: next_s.rdata = st;
				MFID_OFS_IRQ_STAT: next_s.rdata[MFID_EV_W-1:0] = s.irq_stat;
				MFID_OFS_IRQ_MASK: next_s.rdata[MFID_EV_W-1:0] = s.irq_mask;
				default: next_s.slverr = 1'b1;
			endcase
		end
		else if (access)
			next_s.rdata = '0;
		else
			next_s.rdata = s.rdata;
	end

	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			s <= '0;
			s.func <= MFID_RST_FUNC[FW-1:0];
			s.ctrl <= MFID_RST_CTRL;
			s.irq_mask <= MFID_RST_MASK;
			s.mode <= MFID_MODE_OFF;
			s.target <= MFID_MODE_OFF;
		end
		else
			s <= next_s;
	end

	assign prdata = s.rdata;
	assign pready = s.ready;
	assign pslverr = s.slverr;
	assign drive_ctl = s.drv;
	assign nv_write = s.nv_write;
	assign irq = s.irq;
endmodule

/* test/mfid_dispatch_monitor.sv */
// concurrent checks on the ports of the input dispatch block
`timescale 1ns/10ps
module mfid_dispatch_monitor
	import mfid_pkg::*;
#(
	parameter int NUM_TERM = 4
)
(
	input wire logic mclk,
	input wire logic resetn,
	input wire logic [NUM_TERM-1:0] term_in,
	input wire logic keypad_reset,
	input wire mfid_drive_t drive_ctl,
	input wire logic nv_write
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);
	a_fault_stops_drive: assert property (drive_ctl.fault_ind |-> !drive_ctl.run && !drive_ctl.gate_on)
		else $error("drive active during fault");
	a_fault_has_cause: assert property ($rose(drive_ctl.fault_ind) |->
		($past(term_in, 2) | $past(term_in, 3)) != '0)
		else $error("fault without terminal");
	a_fault_needs_key: assert property ($fell(drive_ctl.fault_ind) |->
		$past(keypad_reset, 2) || $past(keypad_reset, 3) || $past(keypad_reset, 4)
		|| $past(keypad_reset, 5))
		else $error("fault cleared without key");
	a_jog_speed_mode: assert property (drive_ctl.jog_rev |-> !drive_ctl.torque_mode)
		else $error("torque mode during jog");
	a_jog_has_cause: assert property ($rose(drive_ctl.jog_rev) |->
		($past(term_in, 2) | $past(term_in, 3)) != '0)
		else $error("jog without terminal");
	a_one_curve: assert property (!(drive_ctl.curve_first && drive_ctl.curve_second))
		else $error("both curves");
	a_nv_single_pulse: assert property (nv_write |=> !nv_write)
		else $error("nv write not a pulse");
	a_hand_auto_excl: assert property (!(drive_ctl.hand && drive_ctl.auto_op))
		else $error("hand and auto together");
	a_mode_entry_idle: assert property ($rose(drive_ctl.hand) || $rose(drive_ctl.auto_op) |->
		!drive_ctl.run && $past(!drive_ctl.run))
		else $error("mode entered while running");
endmodule

/* test/mfid_contacts.sv */
// behavioural model of terminal contacts and the operator reset key
`timescale 1ns/10ps
module mfid_contacts #(
	parameter int SLOW = 0
)
(
	input wire logic mclk,
	input wire logic [3:0] want,
	input wire logic press,
	output logic [3:0] term_in,
	output logic keypad_reset
);
	logic [3:0] late = 4'h0;
	int hold = 0;
	initial term_in = 4'h0;
	initial keypad_reset = 1'b0;
	always @(posedge mclk)
	begin
		late <= want;
		// slow contacts close two cycles behind the command
		term_in <= (SLOW != 0) ? late : want;
		// the operator holds the key a few cycles, never a one-cycle blip
		hold <= press ? 4 : ((hold > 0) ? hold - 1 : 0);
		keypad_reset <= press || hold > 1;
	end
endmodule

/* test/mfid_dispatch_tb.sv */
// self-checking bench: apb registers and terminal scenarios
`timescale 1ns/10ps
module mfid_dispatch_tb;
	import mfid_pkg::*;
	localparam logic [7:0] CT = MFID_OFS_CTRL;
	localparam logic [7:0] ST = MFID_OFS_STATUS;
	logic mclk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic press = 1'b0, motor_stopped = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] want = 4'h0;
	logic [31:0] prdata;
	logic pready, pslverr, nv_write, irq, keypad_reset;
	logic [3:0] term_in;
	mfid_drive_t drive_ctl;
	logic [32:0] eq[$], mq[$];
	int err_total = 0, n_tests = 0, nv_cnt = 0;
	logic [7:0] junk;
	always #5 mclk = ~mclk;
	mfid_contacts #(.SLOW(1)) u_sw (.mclk(mclk), .want(want), .press(press), .term_in(term_in),
		.keypad_reset(keypad_reset));
	mfid_dispatch #(.NUM_TERM(4)) u_dut (.mclk(mclk), .resetn(resetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .term_in(term_in), .keypad_reset(keypad_reset),
		.motor_stopped(motor_stopped), .drive_ctl(drive_ctl), .nv_write(nv_write), .irq(irq));
	task chk(input logic [32:0] got, input logic [32:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			err_total++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task wrap_up;
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task tick(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [32:0] e, input logic [32:0] m);
		if (!w)
		begin
			eq.push_back(e & m);
			mq.push_back(m);
		end
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do
			@(posedge mclk);
		while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk);
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 33'h0, 33'h0);
	endtask
	task rd(input logic [7:0] a, input logic [32:0] e, input logic [32:0] m);
		apb(1'b0, a, 32'h0, e, m | 33'h1_0000_0000);
	endtask
	task key;
		press <= 1'b1;
		tick(1);
		press <= 1'b0;
		tick(8);
	endtask
	// read results are judged when pready shows, against the oldest note
	always @(posedge mclk)
	begin
		if (nv_write === 1'b1)
			nv_cnt++;
		if (psel && penable && !pwrite && pready === 1'b1)
			chk({pslverr, prdata} & mq.pop_front(), eq.pop_front());
	end
	initial
	begin
		#100000;
		err_total++;
		wrap_up;
	end
	initial
	begin
		void'($urandom(32'h6d08));
		tick(16);
		resetn <= 1'b1;
		rd(CT, 33'h0, 33'hf);
		rd(MFID_OFS_IRQ_MASK, 33'h0, 33'h1f);
		wr(MFID_OFS_FUNC, 32'h2a291c19);
		rd(MFID_OFS_FUNC, 33'h2a291c19, 33'hffffffff);
		rd(8'h20, 33'h1_0000_0000, 33'hffffffff);
		wr(MFID_OFS_IRQ_MASK, 32'h1f);
		wr(CT, 32'h6);
		want <= 4'h1;
		tick(8);
		rd(ST, 33'h3, 33'h43);
		want <= 4'h0;
		tick(8);
		rd(ST, 33'h40, 33'h43);
		wr(CT, 32'h4);
		want <= 4'h1;
		tick(8);
		rd(ST, 33'h40, 33'h43);
		wr(CT, 32'h3);
		want <= 4'h2;
		tick(8);
		chk(drive_ctl.gate_on, 33'h0);
		rd(ST, 33'h4, 33'h5);
		chk(irq, 33'h1);
		wr(MFID_OFS_IRQ_MASK, 32'h0);
		tick(2);
		chk(irq, 33'h0);
		wr(MFID_OFS_IRQ_MASK, 32'h1f);
		key;
		rd(ST, 33'h4, 33'h4);
		want <= 4'h0;
		tick(8);
		rd(ST, 33'h4, 33'h4);
		key;
		rd(ST, 33'h0, 33'h5);
		rd(MFID_OFS_IRQ_STAT, 33'h1, 33'h1);
		wr(MFID_OFS_IRQ_STAT, 32'h1f);
		tick(2);
		chk(irq, 33'h0);
		wr(MFID_OFS_FUNC, 32'h28261e1d);
		for (int i = 0; i < 4; i++)
		begin
			wr(CT, (i == 3) ? 32'h0 : 32'h8);
			want <= (i == 3) ? 4'h1 : 4'(i + 1);
			tick(8);
			rd(ST, {27'h0, (i == 3) ? 2'h0 : ((i == 1) ? 2'h2 : 2'h1), 4'h0}, 33'h30);
		end
		want <= 4'h4;
		tick(8);
		wr(MFID_OFS_NVREQ, 32'h1);
		tick(4);
		chk(nv_cnt, 33'h0);
		rd(MFID_OFS_IRQ_STAT, 33'h10, 33'h10);
		want <= 4'h0;
		tick(8);
		wr(MFID_OFS_NVREQ, 32'h1);
		tick(4);
		chk(nv_cnt, 33'h1);
		wr(CT, 32'h1);
		tick(2);
		rd(ST, 33'h1, 33'h1);
		want <= 4'h8;
		tick(8);
		chk(drive_ctl.gate_on, 33'h0);
		rd(ST, 33'h8, 33'h9);
		want <= 4'h0;
		// let the coast terminal settle low before it is recoded as auto
		tick(8);
		junk = 8'($urandom_range(24));
		wr(MFID_OFS_FUNC, {16'h2a29, 8'h00, junk});
		want <= 4'h3;
		tick(8);
		rd(ST, 33'h0, 33'h7ff);
		want <= 4'h4;
		tick(8);
		rd(ST, 33'h400, 33'h700);
		motor_stopped <= 1'b1;
		tick(8);
		rd(ST, 33'h100, 33'h701);
		wr(CT, 32'h1);
		tick(2);
		rd(ST, 33'h1, 33'h1);
		want <= 4'h0;
		tick(8);
		rd(ST, 33'h0, 33'h1);
		want <= 4'h8;
		tick(8);
		rd(ST, 33'h200, 33'h701);
		rd(MFID_OFS_IRQ_STAT, 33'hc, 33'hc);
		tick(4);
		wrap_up;
	end
endmodule
bind mfid_dispatch mfid_dispatch_monitor #(.NUM_TERM(NUM_TERM)) u_mon (.mclk(mclk),
	.resetn(resetn), .term_in(term_in), .keypad_reset(keypad_reset),
	.drive_ctl(drive_ctl), .nv_write(nv_write));
